// [hdl/ppd_pkg.sv]
// Package of constants and types for the PWM phase, dead-time and trigger block
package ppd_pkg;

  // ********************************************************************
  // Register map (byte addresses, one aligned word each)
  // ********************************************************************
  localparam logic [7:0] ADDR_SEC_DUTY = 8'h00;
  localparam logic [7:0] ADDR_PRI_PHASE = 8'h04;
  localparam logic [7:0] ADDR_SEC_PHASE = 8'h08;
  localparam logic [7:0] ADDR_DT_PRI = 8'h0C;
  localparam logic [7:0] ADDR_DT_ALT = 8'h10;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h14;
  localparam logic [7:0] ADDR_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_PRI_DUTY = 8'h1C;
  localparam logic [7:0] ADDR_MASTER_PER = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

  // ********************************************************************
  // Field layouts
  // ********************************************************************
  localparam int DT_MSB = 13;
  localparam int TDIV_LSB = 12;
  localparam int TSTRT_MSB = 5;
  localparam int CTL_ENABLE = 0;
  localparam int CTL_IMMED = 1;
  localparam int CTL_ITB = 2;
  localparam int CTL_PIN_PAIR_MODE_LSB = 3;
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_TRIGGER = 1;
  localparam int IRQ_BITS = 2;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] DT_MASK = 16'h3FFF;
  localparam logic [15:0] TRG_MASK = 16'hF03F;
  localparam logic [15:0] CTL_MASK = 16'h001F;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    PM_COMPLEMENTARY = 2'h0,
    PM_REDUNDANT = 2'h1,
    PM_PUSH_PULL = 2'h2,
    PM_INDEPENDENT = 2'h3
  } ppd_pmode_t;

  typedef struct packed {
    logic [15:0] duty;
    logic [15:0] secDuty;
    logic [15:0] phase;
    logic [15:0] secPhase;
    logic [13:0] deadPri;
    logic [13:0] deadAlt;
  } ppd_timing_t;

endpackage

// [hdl/ppd_channel.sv]
// One PWM channel: timing registers, two time bases, dead time, trigger
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

// Functional notes
// RULE1: Secondary duty drives low side, independent only
// RULE2: INDEPENDENT_PERIOD_SEL clear, paired modes: phase shifts both
// RULE3: INDEPENDENT_PERIOD_SEL set, paired modes: phase is period
// RULE4: Paired modes ignore the secondary phase register
// RULE5: Independent, INDEPENDENT_PERIOD_SEL clear: secondary phase shifts low
// RULE6: Independent, INDEPENDENT_PERIOD_SEL set: secondary phase is low period
// RULE7: Primary dead time 14 bits, top reads zero
// RULE8: Alternate dead time 14 bits, top reads zero
// RULE9: Trigger every (N+1)th event
// RULE10: First trigger delayed N PWM cycles after enable
// RULE11: Only primary generator raises trigger interrupts
// RULE12: Pin mode 11 indep, 10 push-pull, 01 redundant, 00 compl
// RULE13: Active values load at period end unless immediate
// RULE14: INDEPENDENT_PERIOD_SEL set uses phase as period, else master period
// RULE15: Disable clears postscaler and start-delay counts
// RULE16: Six timing registers reset zero, full word access
module ppd_channel
  import ppd_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic wb_we_i, // Write strobe
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic highSideOut, // High-side gate drive
  output logic lowSideOut, // Low-side gate drive
  output logic adcTrigger, // One-cycle ADC trigger pulse
  output logic irq // Level interrupt
);

  // ********************************************************************
  // Register file
  // ********************************************************************
  logic [15:0] secDuty_reg, priPhase_reg, secPhase_reg;
  logic [15:0] deadPri_reg, deadAlt_reg, trigCtrl_reg;
  logic [15:0] control_reg, priDuty_reg, masterPer_reg;
  logic [IRQ_BITS-1:0] irqStat_reg, irqMask_reg;
  ppd_timing_t active_reg, shadow;
  logic enable, immediate, independent_period_sel;
  ppd_pmode_t pmode;
  logic busReq, wrReq, rdStat;
  logic priEnd, secEnd, trigEvent, trigFire;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  assign enable = control_reg[CTL_ENABLE];
  assign immediate = control_reg[CTL_IMMED];
  assign independent_period_sel = control_reg[CTL_ITB];
  assign pmode = ppd_pmode_t'(control_reg[CTL_PIN_PAIR_MODE_LSB +: 2]); // RULE12
  // Ack low in the term keeps a request held through its ack from being
  // taken twice: the slave answers every other cycle at most
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrReq = busReq && wb_we_i;
  assign rdStat = busReq && !wb_we_i && wb_adr_i == ADDR_IRQ_STATUS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secDuty_reg <= RESET_WORD; // RULE16
      priPhase_reg <= RESET_WORD;
      secPhase_reg <= RESET_WORD;
      deadPri_reg <= RESET_WORD;
      deadAlt_reg <= RESET_WORD;
      trigCtrl_reg <= RESET_WORD;
      control_reg <= RESET_WORD;
      priDuty_reg <= RESET_WORD;
      masterPer_reg <= RESET_WORD;
      irqMask_reg <= '0;
    end else if (wrReq) begin
      // Reserved bits are masked here, so they can only read back zero
      unique case (wb_adr_i)
        ADDR_SEC_DUTY: secDuty_reg <= merge16(secDuty_reg, wb_dat_i,
                                               wb_sel_i);
        ADDR_PRI_PHASE: priPhase_reg <= merge16(priPhase_reg, wb_dat_i,
                                                 wb_sel_i);
        ADDR_SEC_PHASE: secPhase_reg <= merge16(secPhase_reg, wb_dat_i,
                                                 wb_sel_i);
        ADDR_DT_PRI: deadPri_reg <= merge16(deadPri_reg, wb_dat_i,
                                             wb_sel_i) & DT_MASK; // RULE7
        ADDR_DT_ALT: deadAlt_reg <= merge16(deadAlt_reg, wb_dat_i,
                                             wb_sel_i) & DT_MASK; // RULE8
        ADDR_TRIG_CTRL: trigCtrl_reg <= merge16(trigCtrl_reg, wb_dat_i,
                                                 wb_sel_i) & TRG_MASK;
        ADDR_CONTROL: control_reg <= merge16(control_reg, wb_dat_i,
                                              wb_sel_i) & CTL_MASK;
        ADDR_PRI_DUTY: priDuty_reg <= merge16(priDuty_reg, wb_dat_i,
                                               wb_sel_i);
        ADDR_MASTER_PER: masterPer_reg <= merge16(masterPer_reg, wb_dat_i,
                                                   wb_sel_i);
        ADDR_IRQ_MASK: if (wb_sel_i[0]) irqMask_reg <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // Unmapped addresses still ack and read zero so the bus never hangs
  // Read data is zero outside ack, so slave outputs can be ORed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= '0;
      if (busReq && !wb_we_i) begin
        unique case (wb_adr_i)
          ADDR_SEC_DUTY: wb_dat_o <= {16'h0000, secDuty_reg};
          ADDR_PRI_PHASE: wb_dat_o <= {16'h0000, priPhase_reg};
          ADDR_SEC_PHASE: wb_dat_o <= {16'h0000, secPhase_reg};
          ADDR_DT_PRI: wb_dat_o <= {16'h0000, deadPri_reg};
          ADDR_DT_ALT: wb_dat_o <= {16'h0000, deadAlt_reg};
          ADDR_TRIG_CTRL: wb_dat_o <= {16'h0000, trigCtrl_reg};
          ADDR_CONTROL: wb_dat_o <= {16'h0000, control_reg};
          ADDR_PRI_DUTY: wb_dat_o <= {16'h0000, priDuty_reg};
          ADDR_MASTER_PER: wb_dat_o <= {16'h0000, masterPer_reg};
          ADDR_IRQ_STATUS: wb_dat_o <= {30'h00000000, irqStat_reg};
          ADDR_IRQ_MASK: wb_dat_o <= {30'h00000000, irqMask_reg};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ********************************************************************
  // Active copies of the timing values
  // ********************************************************************
  assign shadow = '{duty: priDuty_reg, secDuty: secDuty_reg,
                    phase: priPhase_reg, secPhase: secPhase_reg,
                    deadPri: deadPri_reg[DT_MSB:0],
                    deadAlt: deadAlt_reg[DT_MSB:0]};

  // Copies follow the writable registers freely while disabled, so the
  // first period after enable already uses the values written before it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      active_reg <= '0;
    else if (immediate || !enable || priEnd) // RULE13
      active_reg <= shadow;
  end

  // ********************************************************************
  // Time bases
  // ********************************************************************
  logic [15:0] priCnt_reg, secCnt_reg, priPeriod, secPeriod;
  logic indep;
  assign indep = pmode == PM_INDEPENDENT;
  assign priPeriod = independent_period_sel ? active_reg.phase : masterPer_reg; // RULE14 RULE3
  // Low side gets its own period only in independent mode
  assign secPeriod = (indep && independent_period_sel) ? active_reg.secPhase : priPeriod; // RULE6
  // Greater-or-equal, not equal: a period written below the running count
  // ends the period at once instead of letting the counter run to wrap
  assign priEnd = priCnt_reg >= priPeriod;
  assign secEnd = secCnt_reg >= secPeriod;

  // With INDEPENDENT_PERIOD_SEL clear, phase loads as the counter start when the channel comes up; set, the counter starts at zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      priCnt_reg <= '0;
      secCnt_reg <= '0;
    end else if (!enable) begin
      priCnt_reg <= independent_period_sel ? 16'h0000 : shadow.phase; // RULE2
      secCnt_reg <= (!indep) ? (independent_period_sel ? 16'h0000 : shadow.phase) // RULE4
                  : (independent_period_sel ? 16'h0000 : shadow.secPhase); // RULE5
    end else begin
      priCnt_reg <= priEnd ? 16'h0000 : priCnt_reg + 16'h0001;
      secCnt_reg <= secEnd ? 16'h0000 : secCnt_reg + 16'h0001;
    end
  end

  // ********************************************************************
  // Outputs with dead time
  // ********************************************************************
  logic rawH, rawL, prevH_reg, hEdge, dtBlank;
  logic [13:0] dtCnt_reg, dtEdgeVal;
  assign rawH = priCnt_reg < active_reg.duty;
  assign rawL = secCnt_reg < active_reg.secDuty; // RULE1
  // The band opens in the very cycle the high side changes, so neither
  // gate shows the new level before the band has run out; a late band
  // would let a short glitch reach the gate driver first
  assign hEdge = rawH != prevH_reg;
  assign dtEdgeVal = rawH ? active_reg.deadPri // RULE7
                          : active_reg.deadAlt; // RULE8
  assign dtBlank = hEdge ? dtEdgeVal != 14'h0000 : dtCnt_reg != 14'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevH_reg <= 1'b0;
      dtCnt_reg <= '0;
    end else if (!enable) begin
      // Cleared so that the first rise after enable gets its band too
      prevH_reg <= 1'b0;
      dtCnt_reg <= '0;
    end else begin
      prevH_reg <= rawH;
      if (hEdge)
        dtCnt_reg <= dtBlank ? dtEdgeVal - 14'h0001 : 14'h0000;
      else if (dtBlank)
        dtCnt_reg <= dtCnt_reg - 14'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highSideOut <= 1'b0;
      lowSideOut <= 1'b0;
    end else if (!enable) begin
      highSideOut <= 1'b0;
      lowSideOut <= 1'b0;
    end else begin
      unique case (pmode)
        PM_COMPLEMENTARY: begin
          highSideOut <= rawH && !dtBlank; // RULE7
          lowSideOut <= !rawH && !dtBlank; // RULE8
        end
        // Both pins carry the high-side waveform
        PM_REDUNDANT: begin
          highSideOut <= rawH;
          lowSideOut <= rawH;
        end
        // Alternates on the counter LSB: a simplification, not the
        // period-by-period alternation of a full push-pull stage
        PM_PUSH_PULL: begin
          highSideOut <= rawH && !priCnt_reg[0];
          lowSideOut <= rawH && priCnt_reg[0];
        end
        PM_INDEPENDENT: begin
          highSideOut <= rawH;
          lowSideOut <= rawL; // RULE1
        end
      endcase
    end
  end

  // ********************************************************************
  // Trigger postscaler and start delay
  // ********************************************************************
  logic [3:0] postCnt_reg;
  logic [5:0] startCnt_reg;
  logic started;
  // The start count stops once it reaches the delay, so it never wraps
  assign started = startCnt_reg >= trigCtrl_reg[TSTRT_MSB:0];
  // Trigger event is the primary period start; secondary never triggers
  assign trigEvent = enable && priEnd && started; // RULE11
  assign trigFire = trigEvent
                    && postCnt_reg == trigCtrl_reg[TDIV_LSB +: 4]; // RULE9

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      postCnt_reg <= '0;
      startCnt_reg <= '0;
      adcTrigger <= 1'b0;
    end else if (!enable) begin
      postCnt_reg <= '0; // RULE15
      startCnt_reg <= '0;
      adcTrigger <= 1'b0;
    end else begin
      adcTrigger <= trigFire;
      if (priEnd && !started)
        startCnt_reg <= startCnt_reg + 6'h01; // RULE10
      if (trigEvent)
        postCnt_reg <= trigFire ? 4'h0 : postCnt_reg + 4'h1; // RULE9
    end
  end

  // ********************************************************************
  // Interrupts: set wins over the read-clear
  // ********************************************************************
  logic [IRQ_BITS-1:0] irqSet, irqStat_next;
  assign irqSet = {trigFire, enable && priEnd}; // RULE11
  // Event bits are sticky; an event in the cycle of the clearing read
  // survives it, so no event is ever lost between two reads
  assign irqStat_next = (rdStat ? '0 : irqStat_reg) | irqSet;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_reg <= '0;
      irq <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      irq <= |(irqStat_next & irqMask_reg);
    end
  end

endmodule

// [bench/ppd_channel_assertions.sv]
// Port-level checks for the PWM channel
`timescale 1ns/1ps
module ppd_channel_assertions
  import ppd_pkg::*;
(
  input logic clk, // Clock
  input logic rstn, // Reset, active low
  input logic [7:0] wb_adr_i, // Address
  input logic [31:0] wb_dat_i, // Write data
  input logic [3:0] wb_sel_i, // Byte enables
  input logic wb_we_i, // Write
  input logic wb_cyc_i, // Cycle
  input logic wb_stb_i, // Strobe
  input logic [31:0] wb_dat_o, // Read data
  input logic wb_ack_o, // Acknowledge
  input logic highSideOut, // High side
  input logic lowSideOut, // Low side
  input logic adcTrigger, // ADC trigger
  input logic irq // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] adrQ;
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Address of the request being answered, for read-back checks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) adrQ <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o) adrQ <= wb_adr_i;
  end
  a_ack_follows_req: assert property (sReq |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_has_req: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dead_top_zero: assert property (wb_ack_o && (adrQ == ADDR_DT_PRI ||
    adrQ == ADDR_DT_ALT) |-> wb_dat_o[31:14] == 18'h0)
    else $error("dead time top bits set");
  a_trig_gaps_zero: assert property (wb_ack_o && adrQ == ADDR_TRIG_CTRL
    |-> (wb_dat_o & ~{16'h0, TRG_MASK}) == 32'h0)
    else $error("trigger control gap bits set");
  a_unmapped_zero: assert property (wb_ack_o && adrQ > ADDR_IRQ_MASK
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_trig_pulse_one: assert property (adcTrigger |=> !adcTrigger)
    else $error("trigger pulse too long");
endmodule

// [bench/ppd_stage.sv]
// Gate driver and ADC input model: counts what the channel sends
`timescale 1ns/1ps
module ppd_stage (
  input logic clk, // Clock
  input logic clr, // Clears the counts
  input logic highSideOut, // High-side gate
  input logic lowSideOut, // Low-side gate
  input logic adcTrigger, // ADC start
  output int hiCnt, // High-side on cycles
  output int loCnt, // Low-side on cycles
  output int trgCnt // Conversions started
);
  always_ff @(posedge clk) begin
    if (clr) begin
      hiCnt <= 0;
      loCnt <= 0;
      trgCnt <= 0;
    end else begin
      hiCnt <= hiCnt + int'(highSideOut);
      loCnt <= loCnt + int'(lowSideOut);
      trgCnt <= trgCnt + int'(adcTrigger);
    end
  end
endmodule

// [bench/ppd_channel_bench.sv]
// Self-checking bench for the PWM channel
`timescale 1ns/1ps
module ppd_channel_bench
  import ppd_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic clr = 1'b1;
  logic [31:0] rdat, q;
  logic ack, hi, lo, trg, irq;
  logic [15:0] d;
  int dp, da;
  int hiCnt, loCnt, trgCnt;
  int fail_count = 0;
  int num_checks = 0;
  logic [7:0] regs [6] = '{ADDR_SEC_DUTY, ADDR_PRI_PHASE, ADDR_SEC_PHASE,
    ADDR_DT_PRI, ADDR_DT_ALT, ADDR_TRIG_CTRL};
  logic [3:0] tn [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
  logic [5:0] ts [4] = '{6'h05, 6'h00, 6'h02, 6'h00};
  always #5 clk = ~clk;
  ppd_channel dut (.clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .highSideOut(hi), .lowSideOut(lo),
    .adcTrigger(trg), .irq(irq));
  ppd_stage stage (.clk(clk), .clr(clr), .highSideOut(hi), .lowSideOut(lo),
    .adcTrigger(trg), .hiCnt(hiCnt), .loCnt(loCnt), .trgCnt(trgCnt));
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; ack and read data are taken at the rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, 16'h0, v, 4'h3};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      final_report();
    end
    q = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic cfg(input logic [15:0] sd, ph, sp, mp, ctl);
    bus(ADDR_CONTROL, 1'b1, 16'h0000);
    bus(ADDR_SEC_DUTY, 1'b1, sd);
    bus(ADDR_PRI_PHASE, 1'b1, ph);
    bus(ADDR_SEC_PHASE, 1'b1, sp);
    bus(ADDR_MASTER_PER, 1'b1, mp);
    bus(ADDR_CONTROL, 1'b1, ctl);
    repeat (20) @(posedge clk);
  endtask
  // The 100-cycle duty windows are a whole number of periods, so phase does not matter
  task automatic meas(input logic [15:0] ctl, input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    if (ctl != 16'h0) bus(ADDR_CONTROL, 1'b1, ctl);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [15:0] expVal(logic [7:0] a, logic [15:0] v);
    if (a == ADDR_DT_PRI || a == ADDR_DT_ALT) return v & 16'h3FFF;
    if (a == ADDR_TRIG_CTRL) return v & 16'hF03F;
    return v;
  endfunction
  function automatic int trigExp(int ev, int n, int s);
    return (ev - s) / (n + 1);
  endfunction
  initial begin
    void'($urandom(87));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) begin
      bus(regs[i], 1'b0, 16'h0000);
      chk(q, 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      foreach (regs[i]) begin
        d = (p == 0) ? 16'hFFFF : 16'($urandom);
        bus(regs[i], 1'b1, d);
        bus(regs[i], 1'b0, 16'h0000);
        chk(q, {16'h0, expVal(regs[i], d)});
      end
    end
    bus(8'h3C, 1'b1, 16'hFFFF);
    bus(8'h3C, 1'b0, 16'h0000);
    chk(q, 32'h0);
    foreach (regs[i]) bus(regs[i], 1'b1, 16'h0000);
    bus(ADDR_PRI_DUTY, 1'b1, 16'h0003);
    d = 16'(1 + $urandom_range(7));
    cfg(d, 16'h0, 16'h0, 16'h0009, 16'h0019);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'd30);
    chk(32'(loCnt), 32'(10 * d));
    cfg(d, 16'h0, 16'($urandom_range(9)), 16'h0009, 16'h0001);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'd30);
    chk(32'(loCnt), 32'd70);
    dp = 1 + $urandom_range(1);
    da = 1 + $urandom_range(5);
    bus(ADDR_DT_PRI, 1'b1, 16'(dp));
    bus(ADDR_DT_ALT, 1'b1, 16'(da));
    cfg(16'h0, 16'h0, 16'h0, 16'h0009, 16'h0001);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'(10 * (3 - dp)));
    chk(32'(loCnt), 32'(10 * (7 - da)));
    cfg(16'h0, 16'h0, 16'h0, 16'h0009, 16'h0009);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'd30);
    chk(32'(loCnt), 32'd30);
    cfg(16'h0, 16'h0, 16'h0, 16'h0009, 16'h0011);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'd20);
    chk(32'(loCnt), 32'd10);
    cfg(16'h0002, 16'h0009, 16'h0004, 16'h0004, 16'h001D);
    meas(16'h0, 100);
    chk(32'(hiCnt), 32'd30);
    chk(32'(loCnt), 32'd40);
    chk(32'(trgCnt), 32'd10);
    cfg(16'h0, 16'h0, 16'h0, 16'h0004, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      bus(ADDR_CONTROL, 1'b1, 16'h0000);
      bus(ADDR_TRIG_CTRL, 1'b1, {tn[k], 6'h00, ts[k]});
      meas(16'h0001, 162);
      chk(32'(trgCnt), 32'(trigExp(32, tn[k], ts[k])));
    end
    // Duty rewritten early in a long period: held until the boundary
    // unless immediate update is set
    for (int m = 0; m < 2; m++) begin
      bus(ADDR_PRI_DUTY, 1'b1, 16'h0032);
      cfg(16'h0, 16'h0, 16'h0, 16'h0063, 16'h0000);
      meas((m == 0) ? 16'h0009 : 16'h000B, 0);
      bus(ADDR_PRI_DUTY, 1'b1, 16'h000A);
      repeat (60) @(posedge clk);
      @(negedge clk);
      chk(32'(hiCnt), (m == 0) ? 32'd50 : 32'd10);
    end
    bus(ADDR_CONTROL, 1'b1, 16'h0000);
    bus(ADDR_IRQ_MASK, 1'b1, 16'h0000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(ADDR_IRQ_MASK, 1'b1, 16'h0003);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(ADDR_IRQ_STATUS, 1'b0, 16'h0000);
    chk(q, 32'h3);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule
bind ppd_channel ppd_channel_assertions chk_i (.clk(clk), .rstn(rstn),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .highSideOut(highSideOut),
  .lowSideOut(lowSideOut), .adcTrigger(adcTrigger), .irq(irq));
